// *** aisq_defines.svh ***
`ifndef AISQ_DEFINES_SVH
`define AISQ_DEFINES_SVH
// Register indices; byte address is four times the index
`define AISQ_IDX_MASTER_CTRL  8'h24
`define AISQ_IDX_TARGET       8'h25
`define AISQ_IDX_START        8'h26
`define AISQ_IDX_CTRL         8'h27
`define AISQ_IDX_SHARED_DLY   8'h34
`define AISQ_IDX_STATUS       8'h36
`define AISQ_IDX_RESULT0      8'h49
`define AISQ_IDX_WRITE_BYTE   8'h63
`define AISQ_IDX_RATE_SEL     8'h67
// Field positions
`define AISQ_DIR_BIT          7
`define AISQ_ENABLE_BIT       7
`define AISQ_SWAP_BIT         6
`define AISQ_SKIP_REG_BIT     5
`define AISQ_GROUP_BIT        4
`define AISQ_LEN_MSB          3
`define AISQ_NSR_BIT          4
`define AISQ_DLY_MSB          4
`define AISQ_STAT_BUSY_BIT    0
`define AISQ_STAT_NACK_BIT    1
// Reset values
`define AISQ_REG_RESET        8'h00
`define AISQ_WORD_RESET       32'h0000_0000
`endif

// *** aisq_engine_model.sv ***
`timescale 1ns/1ps
module aisq_engine_model
  import aisq_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h2C
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [3:0]   delay_in,
  input  wire logic         cmd_valid_in,
  input  wire aisq_cmd_type cmd_code_in,
  input  wire logic [7:0]   cmd_byte_in,
  output logic              done_out,
  output logic              ack_out,
  output logic [7:0]        rx_byte_out
);
  logic [7:0]   mem [256];
  logic [7:0]   ptr;
  logic [7:0]   byte_q;
  logic [3:0]   wait_cnt;
  logic         busy;
  logic         addr_next;
  logic         ptr_next;
  logic         selected;
  aisq_cmd_type code_q;

  // Fixed formula so the bench can predict sensor contents
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i * 3 + 17);
    end
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy <= 1'h0;
      done_out <= 1'h0;
      ack_out <= 1'h0;
      rx_byte_out <= 8'h00;
      wait_cnt <= 4'h0;
      addr_next <= 1'h0;
      ptr_next <= 1'h0;
      selected <= 1'h0;
      ptr <= 8'h00;
    end else begin
      done_out <= 1'h0;
      // Outside a completion the answer lines invert every cycle and carry no valid value
      ack_out <= ~ack_out;
      rx_byte_out <= ~rx_byte_out;
      if (cmd_valid_in) begin
        busy <= 1'h1;
        wait_cnt <= delay_in;
        code_q <= cmd_code_in;
        byte_q <= cmd_byte_in;
      end else if (busy && wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
      end else if (busy) begin
        busy <= 1'h0;
        done_out <= 1'h1;
        case (code_q)
          AISQ_CMD_START, AISQ_CMD_RESTART: addr_next <= 1'h1;
          AISQ_CMD_STOP: selected <= 1'h0;
          AISQ_CMD_WRITE: begin
            if (addr_next) begin
              addr_next <= 1'h0;
              selected <= (byte_q[7:1] == SLAVE_ADDR);
              ack_out <= (byte_q[7:1] == SLAVE_ADDR);
              ptr_next <= ~byte_q[0];
            end else begin
              ack_out <= selected;
              if (selected && ptr_next) begin
                ptr <= byte_q;
                ptr_next <= 1'h0;
              end else if (selected) begin
                mem[ptr] <= byte_q;
                ptr <= ptr + 8'h01;
              end
            end
          end
          default: begin
            rx_byte_out <= mem[ptr];
            ptr <= ptr + 8'h01;
          end
        endcase
      end
    end
  end
endmodule // aisq_engine_model

// *** aisq_pkg.sv ***
package aisq_pkg;
  typedef enum logic [2:0] {
    AISQ_IDLE    = 3'h0,
    AISQ_START   = 3'h1,
    AISQ_ADDR    = 3'h3,
    AISQ_REGADR  = 3'h2,
    AISQ_RESTART = 3'h6,
    AISQ_RADDR   = 3'h7,
    AISQ_DATA    = 3'h5,
    AISQ_STOP    = 3'h4
  } aisq_state_type;
  typedef enum logic [2:0] {
    AISQ_CMD_START     = 3'h0,
    AISQ_CMD_RESTART   = 3'h1,
    AISQ_CMD_STOP      = 3'h2,
    AISQ_CMD_WRITE     = 3'h3,
    AISQ_CMD_READ_ACK  = 3'h4,
    AISQ_CMD_READ_NACK = 3'h5
  } aisq_cmd_type;
endpackage

// *** aisq_seq.sv ***
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
`include "aisq_defines.svh"
// How it works
// - Direction bit 1 reads from the slave, 0 writes to it.
// - The slave is addressed with the 7-bit target address field.
// - Unless the skip bit is set, each transfer begins at the slave register in the start field.
// - Byte count sets bytes moved; consecutive slave registers follow the start.
// - Read bytes land in the lowest free result registers.
// - Writes send the channel write byte to the slave.
// - A transaction runs only when enabled and the count is nonzero.
// - A zero count acts exactly like a cleared enable.
// - Swap exchanges the bytes of each pair; otherwise arrival order is kept.
// - Grouping clear pairs even-odd registers, set pairs odd-even.
// - An unpartnered leading or trailing byte is stored unswapped.
// - Skip bit sends data only; else register address goes first.
// - Channel runs at sample rate or reduced by the shared delay.
// - Channels are served in fixed order; disabled ones are skipped.
// - A reduced-rate channel not due is skipped, order kept.
// - Reads chain by restart or stop-start; write after read uses stop.
module aisq_seq
  import aisq_pkg::*;
#(
  parameter int RESULT_DEPTH = 24
) (
  input  wire logic         core_clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         hsel_in,
  input  wire logic [31:0]  haddr_in,
  input  wire logic [1:0]   htrans_in,
  input  wire logic         hwrite_in,
  input  wire logic [2:0]   hsize_in,
  input  wire logic [31:0]  hwdata_in,
  input  wire logic         hready_in,
  output logic [31:0]       hrdata_out,
  output logic              hreadyout_out,
  output logic              hresp_out,
  input  wire logic         sample_tick_in,
  output logic              cmd_valid_out,
  output aisq_cmd_type      cmd_code_out,
  output logic [7:0]        cmd_byte_out,
  input  wire logic         cmd_done_in,
  input  wire logic         cmd_ack_in,
  input  wire logic [7:0]   cmd_rx_byte_in,
  output logic              chain_done_out,
  output logic              bus_open_out
);
  // A full count with swapping reaches slot 14; only 24 slots have an address
  if (RESULT_DEPTH < 16 || RESULT_DEPTH > 24) begin : g_depth_check
    $error("RESULT_DEPTH must lie in 16..24");
  end

  function automatic logic [7:0] idx_of(input logic [31:0] addr);
    return addr[9:2];
  endfunction

  logic [7:0]     target_address;
  logic [7:0]     start_register;
  logic [7:0]     transfer_control;
  logic [7:0]     write_byte;
  logic [4:0]     rate_reduction;
  logic           rate_select;
  logic           stop_between_reads;
  logic           nack_seen;
  logic [7:0]     result_mem [RESULT_DEPTH];
  logic           wr_pend;
  logic [7:0]     wr_idx;
  logic [7:0]     rd_idx;
  logic [7:0]     res_off;
  logic [31:0]    next_rdata;
  aisq_state_type state;
  logic           cmd_busy;
  logic [3:0]     byte_idx;
  logic           swap_hold;
  logic           relaunch;
  logic [4:0]     skip_cnt;

  logic       ch0_direction;
  logic [6:0] ch0_target_addr;
  logic       ch0_enable;
  logic       ch0_pair_swap;
  logic       ch0_skip_reg_addr;
  logic       ch0_pair_grouping;
  logic [3:0] ch0_byte_count;
  logic       ch0_active;
  logic       due;
  logic       step_done;
  logic       last_byte;
  logic       pair_first;
  logic [7:0] cur_reg;
  logic [4:0] store_idx;

  assign ch0_direction     = target_address[`AISQ_DIR_BIT];
  assign ch0_target_addr   = target_address[6:0];
  assign ch0_enable        = transfer_control[`AISQ_ENABLE_BIT];
  assign ch0_pair_swap     = transfer_control[`AISQ_SWAP_BIT];
  assign ch0_skip_reg_addr = transfer_control[`AISQ_SKIP_REG_BIT];
  assign ch0_pair_grouping = transfer_control[`AISQ_GROUP_BIT];
  assign ch0_byte_count    = transfer_control[`AISQ_LEN_MSB:0];
  assign ch0_active = ch0_enable && (ch0_byte_count != 4'h0);
  assign due = !rate_select || (skip_cnt == 5'h00);
  assign step_done = cmd_busy && cmd_done_in;
  assign last_byte = (byte_idx == ch0_byte_count - 4'h1);
  assign cur_reg = start_register + {4'h0, byte_idx};
  // First of a pair only when the register parity matches grouping and a partner follows
  assign pair_first = ch0_pair_swap && (cur_reg[0] == ch0_pair_grouping) && !last_byte;
  always_comb begin
    store_idx = {1'b0, byte_idx};
    if (swap_hold) begin
      store_idx = {1'b0, byte_idx} - 5'h01;
    end else if (pair_first) begin
      store_idx = {1'b0, byte_idx} + 5'h01;
    end
  end

  // AHB-Lite: zero wait states, data fetched in the address phase
  assign rd_idx  = idx_of(haddr_in);
  assign res_off = rd_idx - `AISQ_IDX_RESULT0;
  always_comb begin
    next_rdata = `AISQ_WORD_RESET;
    if (rd_idx == `AISQ_IDX_TARGET) begin
      next_rdata[7:0] = target_address;
    end else if (rd_idx == `AISQ_IDX_START) begin
      next_rdata[7:0] = start_register;
    end else if (rd_idx == `AISQ_IDX_CTRL) begin
      next_rdata[7:0] = transfer_control;
    end else if (rd_idx == `AISQ_IDX_WRITE_BYTE) begin
      next_rdata[7:0] = write_byte;
    end else if (rd_idx == `AISQ_IDX_SHARED_DLY) begin
      next_rdata[`AISQ_DLY_MSB:0] = rate_reduction;
    end else if (rd_idx == `AISQ_IDX_RATE_SEL) begin
      next_rdata[0] = rate_select;
    end else if (rd_idx == `AISQ_IDX_MASTER_CTRL) begin
      next_rdata[`AISQ_NSR_BIT] = stop_between_reads;
    end else if (rd_idx == `AISQ_IDX_STATUS) begin
      next_rdata[`AISQ_STAT_BUSY_BIT] = (state != AISQ_IDLE);
      next_rdata[`AISQ_STAT_NACK_BIT] = nack_seen;
    end else if (res_off < 8'(RESULT_DEPTH)) begin
      next_rdata[7:0] = result_mem[res_off[4:0]];
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hrdata_out    <= `AISQ_WORD_RESET;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      wr_pend       <= 1'b0;
      wr_idx        <= `AISQ_REG_RESET;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      wr_pend       <= hsel_in && htrans_in[1] && hready_in && hwrite_in;
      wr_idx        <= rd_idx;
      if (hsel_in && htrans_in[1] && hready_in && !hwrite_in) begin
        hrdata_out <= next_rdata;
      end
    end
  end

  // Config is read live; software must not rewrite it mid-transfer
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      target_address     <= `AISQ_REG_RESET;
      start_register     <= `AISQ_REG_RESET;
      transfer_control   <= `AISQ_REG_RESET;
      write_byte         <= `AISQ_REG_RESET;
      rate_reduction     <= 5'h00;
      rate_select        <= 1'b0;
      stop_between_reads <= 1'b0;
    end else if (wr_pend) begin
      unique case (wr_idx)
        `AISQ_IDX_TARGET:      target_address     <= hwdata_in[7:0];
        `AISQ_IDX_START:       start_register     <= hwdata_in[7:0];
        `AISQ_IDX_CTRL:        transfer_control   <= hwdata_in[7:0];
        `AISQ_IDX_WRITE_BYTE:  write_byte         <= hwdata_in[7:0];
        `AISQ_IDX_SHARED_DLY:  rate_reduction     <= hwdata_in[`AISQ_DLY_MSB:0];
        `AISQ_IDX_RATE_SEL:    rate_select        <= hwdata_in[0];
        `AISQ_IDX_MASTER_CTRL: stop_between_reads <= hwdata_in[`AISQ_NSR_BIT];
        default: ;
      endcase
    end
  end

  // Sticky no-acknowledge flag, write one to clear; a new event wins
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      nack_seen <= 1'b0;
    end else if (step_done && !cmd_ack_in && cmd_code_out == AISQ_CMD_WRITE) begin
      nack_seen <= 1'b1;
    end else if (wr_pend && wr_idx == `AISQ_IDX_STATUS && hwdata_in[`AISQ_STAT_NACK_BIT]) begin
      nack_seen <= 1'b0;
    end
  end

  // Sample-cycle counter: due once every rate_reduction+1 ticks
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      skip_cnt <= 5'h00;
    end else if (sample_tick_in) begin
      if (!rate_select || skip_cnt >= rate_reduction) begin
        skip_cnt <= 5'h00;
      end else begin
        skip_cnt <= skip_cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < RESULT_DEPTH; i++) begin
        result_mem[i] <= `AISQ_REG_RESET;
      end
      swap_hold <= 1'b0;
    end else if (state == AISQ_START) begin
      swap_hold <= 1'b0;
    end else if (state == AISQ_DATA && step_done && ch0_direction) begin
      // Channel 0 is served first, so its lowest free slot is slot 0
      result_mem[store_idx] <= cmd_rx_byte_in;
      swap_hold <= !swap_hold && pair_first;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state          <= AISQ_IDLE;
      cmd_busy       <= 1'b0;
      cmd_valid_out  <= 1'b0;
      cmd_code_out   <= AISQ_CMD_START;
      cmd_byte_out   <= `AISQ_REG_RESET;
      byte_idx       <= 4'h0;
      relaunch       <= 1'b0;
      chain_done_out <= 1'b0;
      bus_open_out   <= 1'b0;
    end else begin
      cmd_valid_out  <= 1'b0;
      chain_done_out <= 1'b0;
      if (state == AISQ_IDLE) begin
        if (sample_tick_in) begin
          if (ch0_active && due) begin
            byte_idx <= 4'h0;
            // Held bus may restart only into another read
            if (bus_open_out && !(ch0_direction && !stop_between_reads)) begin
              state    <= AISQ_STOP;
              relaunch <= 1'b1;
            end else begin
              state <= AISQ_START;
            end
          end else begin
            chain_done_out <= 1'b1;
          end
        end
      end else if (!cmd_busy) begin
        cmd_valid_out <= 1'b1;
        cmd_busy      <= 1'b1;
        cmd_byte_out  <= `AISQ_REG_RESET;
        unique case (state)
          AISQ_START: begin
            cmd_code_out <= bus_open_out ? AISQ_CMD_RESTART : AISQ_CMD_START;
          end
          AISQ_ADDR: begin
            cmd_code_out <= AISQ_CMD_WRITE;
            cmd_byte_out <= {ch0_target_addr, ch0_skip_reg_addr & ch0_direction};
          end
          AISQ_REGADR: begin
            cmd_code_out <= AISQ_CMD_WRITE;
            cmd_byte_out <= start_register;
          end
          AISQ_RESTART: cmd_code_out <= AISQ_CMD_RESTART;
          AISQ_RADDR: begin
            cmd_code_out <= AISQ_CMD_WRITE;
            cmd_byte_out <= {ch0_target_addr, 1'b1};
          end
          AISQ_DATA: begin
            if (ch0_direction) begin
              cmd_code_out <= last_byte ? AISQ_CMD_READ_NACK : AISQ_CMD_READ_ACK;
            end else begin
              cmd_code_out <= AISQ_CMD_WRITE;
              cmd_byte_out <= write_byte;
            end
          end
          AISQ_STOP: cmd_code_out <= AISQ_CMD_STOP;
          default: cmd_code_out <= AISQ_CMD_STOP;
        endcase
      end else if (cmd_done_in) begin
        cmd_busy <= 1'b0;
        unique case (state)
          AISQ_START: begin
            bus_open_out <= 1'b1;
            state        <= AISQ_ADDR;
          end
          AISQ_ADDR: begin
            if (!cmd_ack_in) begin
              state <= AISQ_STOP;
            end else begin
              state <= ch0_skip_reg_addr ? AISQ_DATA : AISQ_REGADR;
            end
          end
          AISQ_REGADR: begin
            if (!cmd_ack_in) begin
              state <= AISQ_STOP;
            end else begin
              state <= ch0_direction ? AISQ_RESTART : AISQ_DATA;
            end
          end
          AISQ_RESTART: state <= AISQ_RADDR;
          AISQ_RADDR: state <= cmd_ack_in ? AISQ_DATA : AISQ_STOP;
          AISQ_DATA: begin
            byte_idx <= byte_idx + 4'h1;
            if (!ch0_direction && !cmd_ack_in) begin
              state <= AISQ_STOP;
            end else if (last_byte) begin
              if (ch0_direction && !stop_between_reads) begin
                state          <= AISQ_IDLE;
                chain_done_out <= 1'b1;
              end else begin
                state <= AISQ_STOP;
              end
            end
          end
          AISQ_STOP: begin
            bus_open_out <= 1'b0;
            relaunch     <= 1'b0;
            state        <= relaunch ? AISQ_START : AISQ_IDLE;
            chain_done_out <= !relaunch;
          end
          default: state <= AISQ_IDLE;
        endcase
      end
    end
  end

  sequence s_reg_then_read;
    state == AISQ_REGADR && step_done && cmd_ack_in && ch0_direction;
  endsequence
  sequence s_restart_issued;
    state == AISQ_RESTART ##1 (cmd_valid_out && cmd_code_out == AISQ_CMD_RESTART);
  endsequence

  a_read_dir_bit: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    cmd_valid_out && state == AISQ_RADDR |-> cmd_byte_out[0] == 1'b1)
    else $error("read address byte lacks read bit");
  a_target_addr_out: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    cmd_valid_out && state == AISQ_ADDR |-> cmd_byte_out[7:1] == ch0_target_addr)
    else $error("wrong slave address sent");
  a_start_reg_sent: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    cmd_valid_out && state == AISQ_REGADR |-> cmd_byte_out == start_register)
    else $error("wrong start register sent");
  a_count_ends: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    state == AISQ_DATA && step_done && last_byte |=> state != AISQ_DATA)
    else $error("data phase overran byte count");
  a_write_data_byte: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    cmd_valid_out && state == AISQ_DATA && !ch0_direction
    |-> cmd_code_out == AISQ_CMD_WRITE && cmd_byte_out == write_byte)
    else $error("write data byte mismatch");
  a_idle_inactive: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    sample_tick_in && state == AISQ_IDLE && !ch0_active |=> state == AISQ_IDLE && chain_done_out)
    else $error("inactive channel launched");
  a_skip_reg_addr: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    state == AISQ_ADDR && step_done && cmd_ack_in && ch0_skip_reg_addr |=> state == AISQ_DATA)
    else $error("register address not skipped");
  a_not_due_skip: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    sample_tick_in && state == AISQ_IDLE && rate_select && skip_cnt != 5'h00
    |=> state == AISQ_IDLE && chain_done_out)
    else $error("channel ran while not due");
  a_restart_follows: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    s_reg_then_read |=> s_restart_issued)
    else $error("no repeated start before read");
  a_read_held_open: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    state == AISQ_DATA && step_done && last_byte && ch0_direction && !stop_between_reads
    |=> state == AISQ_IDLE && bus_open_out ##1 !chain_done_out)
    else $error("read chain not held open");
endmodule // aisq_seq

// *** aisq_seq_tb.sv ***
`timescale 1ns/1ps
`include "aisq_defines.svh"
module aisq_seq_tb
  import aisq_pkg::*;
;
  localparam logic [6:0] SLV = 7'h2C;
  logic         clk = 1'h0;
  logic         rst_n = 1'h1;
  logic         hsel = 1'h0;
  logic [31:0]  haddr = 32'h0;
  logic [1:0]   htrans = 2'h0;
  logic         hwrite = 1'h0;
  logic [31:0]  hwdata = 32'h0;
  logic         tick = 1'h0;
  logic [3:0]   eng_delay = 4'h0;
  logic [31:0]  hrdata;
  logic         hready;
  logic         hresp;
  logic         cmd_valid;
  logic         cmd_done;
  logic         cmd_ack;
  logic         chain_done;
  logic         bus_open;
  aisq_cmd_type cmd_code;
  logic [7:0]   cmd_byte;
  logic [7:0]   rx_byte;
  logic [10:0]  cmdq[$];
  logic [10:0]  expq[$];
  int           miscompares = 0;
  int           samples_checked = 0;
  int           chains = 0;
  int           cycles = 0;

  always #2 clk = ~clk;

  aisq_seq dut (.core_clk_in(clk), .rst_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .sample_tick_in(tick), .cmd_valid_out(cmd_valid), .cmd_code_out(cmd_code),
    .cmd_byte_out(cmd_byte), .cmd_done_in(cmd_done), .cmd_ack_in(cmd_ack),
    .cmd_rx_byte_in(rx_byte), .chain_done_out(chain_done), .bus_open_out(bus_open));

  aisq_engine_model #(.SLAVE_ADDR(SLV)) eng (.clk_in(clk), .rst_n_in(rst_n),
    .delay_in(eng_delay), .cmd_valid_in(cmd_valid), .cmd_code_in(cmd_code),
    .cmd_byte_in(cmd_byte), .done_out(cmd_done), .ack_out(cmd_ack), .rx_byte_out(rx_byte));

  // Sampled mid-cycle, where one-cycle pulses are settled
  always @(negedge clk) begin
    if (cmd_valid === 1'h1) cmdq.push_back({cmd_code, cmd_byte});
    if (chain_done === 1'h1) chains++;
  end

  task automatic conclude;
    if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    do @(posedge clk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'h1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [31:0] x;
    ahb(1'h1, i, {24'h0, d}, x);
  endtask

  task automatic rc(input logic [7:0] i, input logic [7:0] e);
    logic [31:0] x;
    ahb(1'h0, i, 32'h0, x);
    chk(x, {24'h0, e});
    chk({31'h0, hresp}, 32'h0);
  endtask

  function automatic logic [7:0] mv(input logic [7:0] r);
    return r * 8'h03 + 8'h11;
  endfunction

  // Slot i must hold the sensor byte of register p[8*i+:8]
  task automatic res(input int n, input logic [31:0] p);
    for (int i = 0; i < n; i++) rc(8'(`AISQ_IDX_RESULT0 + i), mv(p[8*i+:8]));
  endtask

  task automatic run(input int n);
    int c0;
    repeat (n) begin
      c0 = chains;
      @(posedge clk);
      tick <= 1'h1;
      @(posedge clk);
      tick <= 1'h0;
      while (chains == c0) @(posedge clk);
    end
  endtask

  function automatic void ex(input aisq_cmd_type c, input logic [7:0] b);
    expq.push_back({c, b});
  endfunction

  function automatic void exr(input aisq_cmd_type f, input logic ra, input logic [7:0] r,
                              input int n, input logic stop);
    ex(f, 8'h00);
    if (ra) begin
      ex(AISQ_CMD_WRITE, {SLV, 1'h0});
      ex(AISQ_CMD_WRITE, r);
      ex(AISQ_CMD_RESTART, 8'h00);
    end
    ex(AISQ_CMD_WRITE, {SLV, 1'h1});
    for (int i = 1; i < n; i++) ex(AISQ_CMD_READ_ACK, 8'h00);
    ex(AISQ_CMD_READ_NACK, 8'h00);
    if (stop) ex(AISQ_CMD_STOP, 8'h00);
  endfunction

  task automatic cmp_cmds;
    chk(32'(cmdq.size()), 32'(expq.size()));
    foreach (expq[i]) chk({21'h0, cmdq[i]}, {21'h0, expq[i]});
    cmdq.delete();
    expq.delete();
  endtask

  initial begin
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    rc(`AISQ_IDX_TARGET, 8'h00);
    rc(`AISQ_IDX_START, 8'h00);
    rc(`AISQ_IDX_CTRL, 8'h00);
    wr(8'h7F, 8'hFF);
    rc(8'h7F, 8'h00);
    // Swap, even-odd pairing from an odd start, stop after the read
    wr(`AISQ_IDX_MASTER_CTRL, 8'h10);
    wr(`AISQ_IDX_TARGET, {1'h1, SLV});
    rc(`AISQ_IDX_TARGET, {1'h1, SLV});
    wr(`AISQ_IDX_START, 8'h01);
    wr(`AISQ_IDX_CTRL, 8'hC4);
    rc(`AISQ_IDX_CTRL, 8'hC4);
    eng_delay <= 4'h3;
    run(1);
    exr(AISQ_CMD_START, 1'h1, 8'h01, 4, 1'h1);
    cmp_cmds();
    res(4, 32'h04_02_03_01);
    // Odd-even pairing, restart chaining leaves the bus held
    wr(`AISQ_IDX_MASTER_CTRL, 8'h00);
    wr(`AISQ_IDX_CTRL, 8'hD3);
    eng_delay <= 4'h0;
    run(1);
    exr(AISQ_CMD_START, 1'h1, 8'h01, 3, 1'h0);
    cmp_cmds();
    chk({31'h0, bus_open}, 32'h1);
    res(3, 32'h00_03_01_02);
    // Data-only read while the bus is held: restart, no register address write
    wr(`AISQ_IDX_CTRL, 8'hA1);
    run(1);
    exr(AISQ_CMD_RESTART, 1'h0, 8'h00, 1, 1'h0);
    cmp_cmds();
    res(1, 32'h04);
    // Write after read always closes the bus first
    wr(`AISQ_IDX_TARGET, {1'h0, SLV});
    wr(`AISQ_IDX_START, 8'h10);
    wr(`AISQ_IDX_WRITE_BYTE, 8'h5A);
    wr(`AISQ_IDX_CTRL, 8'h82);
    eng_delay <= 4'h2;
    run(1);
    ex(AISQ_CMD_STOP, 8'h00);
    ex(AISQ_CMD_START, 8'h00);
    ex(AISQ_CMD_WRITE, {SLV, 1'h0});
    ex(AISQ_CMD_WRITE, 8'h10);
    ex(AISQ_CMD_WRITE, 8'h5A);
    ex(AISQ_CMD_WRITE, 8'h5A);
    ex(AISQ_CMD_STOP, 8'h00);
    cmp_cmds();
    chk({24'h0, eng.mem[8'h11]}, 32'h5A);
    chk({31'h0, bus_open}, 32'h0);
    // Disabled channel and zero count both stay silent
    wr(`AISQ_IDX_CTRL, 8'h04);
    run(1);
    wr(`AISQ_IDX_CTRL, 8'h80);
    run(1);
    cmp_cmds();
    // Half rate: two transfers in four ticks, then full rate
    wr(`AISQ_IDX_TARGET, {1'h1, SLV});
    wr(`AISQ_IDX_MASTER_CTRL, 8'h10);
    wr(`AISQ_IDX_SHARED_DLY, 8'h01);
    wr(`AISQ_IDX_RATE_SEL, 8'h01);
    wr(`AISQ_IDX_CTRL, 8'hA1);
    run(4);
    repeat (2) exr(AISQ_CMD_START, 1'h0, 8'h00, 1, 1'h1);
    cmp_cmds();
    wr(`AISQ_IDX_RATE_SEL, 8'h00);
    run(2);
    repeat (2) exr(AISQ_CMD_START, 1'h0, 8'h00, 1, 1'h1);
    cmp_cmds();
    // Absent slave: no acknowledge closes the bus and sets the sticky flag
    wr(`AISQ_IDX_TARGET, {1'h0, SLV + 7'h01});
    wr(`AISQ_IDX_CTRL, 8'h81);
    run(1);
    ex(AISQ_CMD_START, 8'h00);
    ex(AISQ_CMD_WRITE, {SLV + 7'h01, 1'h0});
    ex(AISQ_CMD_STOP, 8'h00);
    cmp_cmds();
    rc(`AISQ_IDX_STATUS, 8'h02);
    wr(`AISQ_IDX_STATUS, 8'h02);
    rc(`AISQ_IDX_STATUS, 8'h00);
    conclude();
  end
endmodule // aisq_seq_tb
